/* File: logic/osc_train_consts.vh */
// constants for the oscillator training block
// assumes a 100 MHz training clock and a 3-bit period code
`ifndef OSC_TRAIN_CONSTS_VH
`define OSC_TRAIN_CONSTS_VH
`define CLK_PERIOD_NS 10
`define INTERVAL_US 4000
`define INTERVAL_CYCLES ((`INTERVAL_US * 1000) / `CLK_PERIOD_NS)
`define PERIOD_MIN_US 500
`define PERIOD_MAX_US 4000
`define SETTLE_US 1000
`define SETTLE_CYCLES ((`SETTLE_US * 1000) / `CLK_PERIOD_NS)
`define BLOCK_US 20
`define BLOCK_CYCLES ((`BLOCK_US * 1000) / `CLK_PERIOD_NS)
`define WINDOW_CYCLES 20000
`define ADJUST_CYCLES 400
`define STEP_SIZE 8'h01
`define TRIM_RESET 8'h00
`define ERRCNT_MAX 7'h7f
`define ERRCNT_RESET 7'h00
`define MODE_PSI5 2'h0
`define MODE_SPI 2'h1
`define MODE_I2C 2'h2
`endif

/* File: logic/period_decode.v */
// decodes the 3-bit period code into period, count per 4 ms and checks
// purely combinational; fed from the register-held period field
`timescale 1ns/100ps
`include "osc_train_consts.vh"
module period_decode (
    // period code
    input wire [2:0] code,
    // decoded values
    output reg [12:0] period_us,
    output reg [3:0] periods_per_interval,
    output reg period_bad
);
    reg [12:0] quot;

    always @* begin
        quot = 13'h0000;
        case (code)
            3'h0: period_us = 13'd500;
            3'h1: period_us = 13'd1000;
            3'h2: period_us = 13'd2000;
            3'h3: period_us = 13'd4000;
            3'h4: period_us = 13'd250;
            3'h5: period_us = 13'd800;
            3'h6: period_us = 13'd1500;
            default: period_us = 13'd8000;
        endcase
        periods_per_interval = 4'h0;
        // quotient never exceeds 8 for the codes that pass the checks
        if (period_us != 13'd0)
            quot = `INTERVAL_US / period_us;
        periods_per_interval = quot[3:0];
        // range and whole-divisor
        period_bad = (period_us < `PERIOD_MIN_US) ||
            (period_us > `PERIOD_MAX_US) ||
            ((`INTERVAL_US % period_us) != 0);
    end
endmodule

/* File: logic/osc_train.v */
// oscillator training against periodic reference events from the master
// events are one-cycle pulses from protocol decoders on the same clock
//
// Function
// - train over 4 ms intervals from period field
// - psi5 sync pulses are reference events
// - count oscillator cycles across reference periods
// - adjust only inside the training window
// - count too high lowers frequency target
// - count too low raises frequency target
// - psi5 applies target after blocking time
// - psi5 ignores sync pulses in phase 1
// - psi5 training starts after settling delay
// - spi uses source zero requests only
// - i2c uses sensor ch0 low byte reads
// - training problems set error flag
// - up/down counter filters window result
// - error flag at programmed threshold
// - error counter saturates at 127 and 0
// - period outside 500 us to 4 ms errors
// - period not dividing 4 ms errors
// - disable keeps or reverts adjustment
`timescale 1ns/100ps
`include "osc_train_consts.vh"
module osc_train (
    // clock and reset
    input wire clk,
    input wire reset,
    // configuration
    input wire train_enable,
    input wire train_revert_on_disable,
    input wire [1:0] mode,
    input wire [2:0] reference_period_field,
    input wire [6:0] train_error_threshold,
    input wire init_phase1,
    // reference events
    input wire sync_pulse,
    input wire source_zero_request,
    input wire sensor_ch0_low_byte,
    // results
    output reg [7:0] freq_target_r,
    output reg train_error_flag_r,
    output reg [6:0] errcnt_r,
    output reg [22:0] measured_cycle_count_r,
    output reg training_active_r
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_MEAS = 2'h2;
    localparam ST_BLOCK = 2'h3;
    localparam [22:0] TYP = `INTERVAL_CYCLES;
    localparam [22:0] WIN = `WINDOW_CYCLES;
    localparam [22:0] ADJ = `ADJUST_CYCLES;
    localparam [17:0] SETTLE_END = `SETTLE_CYCLES - 1;
    localparam [17:0] BLOCK_END = `BLOCK_CYCLES - 1;

    wire [12:0] period_us;
    wire [3:0] n_periods;
    wire period_bad;
    reg [1:0] state_r;
    reg [22:0] cnt_r;
    reg [3:0] ev_r;
    reg [17:0] dly_r;
    reg started_r;
    reg [7:0] pend_r;
    reg err_latched_r;
    reg ref_ev;
    reg [7:0] trim_nxt;
    reg [6:0] errcnt_nxt;
    reg in_win;
    reg too_high;
    reg too_low;
    wire [22:0] count_now;

    period_decode u_dec (
        .code(reference_period_field),
        .period_us(period_us),
        .periods_per_interval(n_periods),
        .period_bad(period_bad)
    );

    assign count_now = cnt_r + 23'h000001;

    // pick the reference event for the current mode
    always @* begin
        case (mode)
            `MODE_PSI5: ref_ev = sync_pulse & ~init_phase1;
            `MODE_SPI: ref_ev = source_zero_request;
            `MODE_I2C: ref_ev = sensor_ch0_low_byte;
            default: ref_ev = 1'b0;
        endcase
    end

    // window decision on the interval just closed
    always @* begin
        in_win = (count_now + WIN >= TYP) && (count_now <= TYP + WIN);
        too_high = count_now > TYP + ADJ;
        too_low = count_now + ADJ < TYP;
        trim_nxt = freq_target_r;
        if (in_win && too_high)
            trim_nxt = freq_target_r - `STEP_SIZE;
        else if (in_win && too_low)
            trim_nxt = freq_target_r + `STEP_SIZE;
        errcnt_nxt = errcnt_r;
        if (!in_win && errcnt_r != `ERRCNT_MAX)
            errcnt_nxt = errcnt_r + 7'h01;
        else if (in_win && errcnt_r != `ERRCNT_RESET)
            errcnt_nxt = errcnt_r - 7'h01;
    end

    always @(posedge clk) begin
        if (reset) begin
            state_r <= ST_IDLE;
            cnt_r <= 23'h000000;
            ev_r <= 4'h0;
            dly_r <= 18'h00000;
            started_r <= 1'b0;
            pend_r <= `TRIM_RESET;
            err_latched_r <= 1'b0;
            freq_target_r <= `TRIM_RESET;
            errcnt_r <= `ERRCNT_RESET;
            train_error_flag_r <= 1'b0;
            measured_cycle_count_r <= 23'h000000;
            training_active_r <= 1'b0;
        end else begin
            // flag covers filter result and bad period while enabled
            train_error_flag_r <= train_enable &&
                (err_latched_r || period_bad);
            if (!train_enable) begin
                state_r <= ST_IDLE;
                training_active_r <= 1'b0;
                cnt_r <= 23'h000000;
                ev_r <= 4'h0;
                if (started_r && train_revert_on_disable) begin
                    freq_target_r <= `TRIM_RESET;
                    started_r <= 1'b0;
                end
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        dly_r <= 18'h00000;
                        state_r <= (mode == `MODE_PSI5) ? ST_WAIT : ST_MEAS;
                    end
                    ST_WAIT: begin
                        // psi5 waits out power-mode settling
                        dly_r <= dly_r + 18'h00001;
                        if (dly_r == SETTLE_END)
                            state_r <= ST_MEAS;
                    end
                    ST_MEAS: begin
                        // first event opens the interval
                        if (!training_active_r) begin
                            if (ref_ev && !period_bad) begin
                                training_active_r <= 1'b1;
                                started_r <= 1'b1;
                                cnt_r <= 23'h000000;
                                ev_r <= 4'h0;
                            end
                        end else if (ref_ev && ev_r + 4'h1 == n_periods) begin
                            measured_cycle_count_r <= count_now;
                            errcnt_r <= errcnt_nxt;
                            if (errcnt_nxt >= train_error_threshold)
                                err_latched_r <= 1'b1;
                            else
                                err_latched_r <= 1'b0;
                            cnt_r <= 23'h000000;
                            ev_r <= 4'h0;
                            if (mode == `MODE_PSI5) begin
                                pend_r <= trim_nxt;
                                dly_r <= 18'h00000;
                                state_r <= ST_BLOCK;
                            end else begin
                                freq_target_r <= trim_nxt;
                            end
                        end else begin
                            // saturate rather than wrap on a lost master
                            if (cnt_r != 23'h7fffff)
                                cnt_r <= count_now;
                            if (ref_ev)
                                ev_r <= ev_r + 4'h1;
                        end
                    end
                    ST_BLOCK: begin
                        // keep counting; the closing event starts next one
                        cnt_r <= count_now;
                        if (ref_ev)
                            ev_r <= ev_r + 4'h1;
                        dly_r <= dly_r + 18'h00001;
                        if (dly_r == BLOCK_END) begin
                            freq_target_r <= pend_r;
                            state_r <= ST_MEAS;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

/* File: tb/ref_master.sv */
// reference master: one-cycle events on one line at a fixed cycle period
// assumes run and period are driven by the bench just after a clock edge
`timescale 1ns/100ps
module ref_master (
    // control
    input wire clk,
    input wire run,
    input wire [1:0] line,
    input wire [22:0] period,
    // events
    output reg sync_pulse = 1'b0,
    output reg source_zero_request = 1'b0,
    output reg sensor_ch0_low_byte = 1'b0
);
    reg [22:0] cnt_r = 23'h0;
    // first event right after run rises, then one per period
    always @(posedge clk) begin
        cnt_r <= (!run || cnt_r == period - 23'h1) ? 23'h0 : cnt_r + 23'h1;
        sync_pulse <= run && cnt_r == 23'h0 && line == 2'h0;
        source_zero_request <= run && cnt_r == 23'h0 && line == 2'h1;
        sensor_ch0_low_byte <= run && cnt_r == 23'h0 && line == 2'h2;
    end
endmodule

/* File: tb/osc_train_sva.sv */
// checker on the ports of osc_train
// assumes the 400000-cycle interval, 400 adjust and 20000 window
`timescale 1ns/100ps
module osc_train_chk (
    input wire clk, reset, train_enable, train_revert_on_disable,
    input wire [1:0] mode,
    input wire [2:0] reference_period_field,
    input wire [6:0] train_error_threshold,
    input wire init_phase1, sync_pulse, source_zero_request,
    input wire sensor_ch0_low_byte, train_error_flag_r, training_active_r,
    input wire [7:0] freq_target_r,
    input wire [6:0] errcnt_r,
    input wire [22:0] measured_cycle_count_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire [22:0] m = measured_cycle_count_r;
    wire ev = sync_pulse | source_zero_request | sensor_ch0_low_byte;
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        reset |=> freq_target_r == 8'h00 && errcnt_r == 7'h00)
        else $error("trim or error count not cleared by reset");
    AST_ERR_STEP: assert property (
        !$past(reset) && !$stable(errcnt_r) |->
        {1'b0, errcnt_r} == {1'b0, $past(errcnt_r)} + 8'h01 ||
        {1'b0, $past(errcnt_r)} == {1'b0, errcnt_r} + 8'h01)
        else $error("error counter jumped or wrapped");
    AST_ADJUST: assert property (
        !$past(reset) && $past(train_enable) && mode != 2'h0 &&
        !$stable(freq_target_r) |->
        (m > 23'd400400 && m <= 23'd420000 &&
        freq_target_r == $past(freq_target_r) - 8'h01) ||
        (m < 23'd399600 && m >= 23'd380000 &&
        freq_target_r == $past(freq_target_r) + 8'h01))
        else $error("trim step does not match the measured count");
    AST_KEEP: assert property (
        !train_enable && !train_revert_on_disable |=> $stable(freq_target_r))
        else $error("trim moved while disabled");
    AST_REVERT: assert property (
        $fell(train_enable) && train_revert_on_disable |->
        ##[0:2] freq_target_r == 8'h00)
        else $error("trim not reverted on disable");
    AST_BAD_CODE: assert property (
        (train_enable && reference_period_field[2]) [*3] |->
        train_error_flag_r) else $error("bad period code not flagged");
    AST_THRESH: assert property (
        (train_enable && !reference_period_field[2] &&
        train_error_threshold != 7'h00 &&
        errcnt_r >= train_error_threshold) [*3] |-> train_error_flag_r)
        else $error("error count at threshold not flagged");
    AST_PHASE1: assert property (
        mode == 2'h0 && init_phase1 && !training_active_r && sync_pulse
        |=> !training_active_r) else $error("sync taken in phase 1");
    AST_MEAS: assert property (
        !$past(reset) && $past(train_enable) && !$stable(m) |-> $past(ev))
        else $error("measured count changed without an event");
    cover property (train_error_flag_r);
    cover property (freq_target_r == 8'hff);
    cover property (freq_target_r == 8'h00 && $past(freq_target_r) == 8'hfe);
endmodule
bind osc_train osc_train_chk chk (.clk, .reset, .train_enable,
    .train_revert_on_disable, .mode, .reference_period_field,
    .train_error_threshold, .init_phase1, .sync_pulse, .source_zero_request,
    .sensor_ch0_low_byte, .train_error_flag_r, .training_active_r,
    .freq_target_r, .errcnt_r, .measured_cycle_count_r);

/* File: tb/tb_osc_train.sv */
// self-checking bench for osc_train driven by a reference master model
// assumes the full 4 ms interval; the run takes a few million cycles
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin samples_checked = samples_checked + 1; \
    if ((got) !== (exp)) begin failures = failures + 1; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb_osc_train;
    reg clk = 1'b0, reset = 1'b1, train_enable = 1'b0, run = 1'b0;
    reg train_revert_on_disable = 1'b0, init_phase1 = 1'b0;
    reg [1:0] mode = 2'h1, line = 2'h1;
    reg [2:0] reference_period_field = 3'h3;
    reg [6:0] train_error_threshold = 7'h7f;
    reg [22:0] period = 23'h1, last;
    wire sync_pulse, source_zero_request, sensor_ch0_low_byte;
    wire train_error_flag_r, training_active_r;
    wire [7:0] freq_target_r;
    wire [6:0] errcnt_r;
    wire [22:0] measured_cycle_count_r;
    integer failures = 0, samples_checked = 0, i, k;
    reg [39:0] rows [0:4];
    always #5 clk = ~clk;
    osc_train DUT (.clk, .reset, .train_enable, .train_revert_on_disable,
        .mode, .reference_period_field, .train_error_threshold, .init_phase1,
        .sync_pulse, .source_zero_request, .sensor_ch0_low_byte,
        .freq_target_r, .train_error_flag_r, .errcnt_r,
        .measured_cycle_count_r, .training_active_r);
    ref_master master (.clk, .run, .line, .period, .sync_pulse,
        .source_zero_request, .sensor_ch0_low_byte);
    task print_verdict; begin
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end endtask
    task tick(input integer n); begin repeat (n) @(posedge clk); #1; end
    endtask
    // restart from idle so the first event opens a fresh interval
    task train(input [1:0] md, input [22:0] p); begin
        train_enable = 1'b0; run = 1'b0; tick(2);
        mode = md; line = md; period = p; last = measured_cycle_count_r;
        train_enable = 1'b1; run = 1'b1; k = 0;
        while (measured_cycle_count_r === last && k < 1000000) begin
            tick(1); k = k + 1; end
        if (k == 1000000) begin failures = failures + 1; print_verdict; end
        tick(2005); // psi5 trim lands after the blocking time
        run = 1'b0;
    end endtask
    initial begin
        // mode, period in cycles, trim, error count
        rows[0] = {2'h1, 23'd410000, 8'hff, 7'h00};
        rows[1] = {2'h2, 23'd390000, 8'h00, 7'h00};
        rows[2] = {2'h0, 23'd410000, 8'hff, 7'h00};
        rows[3] = {2'h1, 23'd430000, 8'hff, 7'h01};
        rows[4] = {2'h1, 23'd410000, 8'hfe, 7'h00};
        tick(3); reset = 1'b0; tick(1);
        `CHK("trim", 8'h00, freq_target_r)
        `CHK("errcnt", 7'h00, errcnt_r)
        for (i = 0; i < 5; i = i + 1) begin
            train(rows[i][39:38], rows[i][37:15]);
            `CHK("trim", rows[i][14:7], freq_target_r)
            `CHK("errcnt", rows[i][6:0], errcnt_r)
            `CHK("measured", 1'b1, measured_cycle_count_r + 23'd1 >= period
                && measured_cycle_count_r <= period + 23'd1)
        end
        train_error_threshold = 7'h01;
        train(2'h1, 23'd430000);
        `CHK("flag", 1'b1, train_error_flag_r)
        `CHK("trim", 8'hfe, freq_target_r)
        train_revert_on_disable = 1'b1; train_enable = 1'b0; tick(3);
        `CHK("trim", 8'h00, freq_target_r)
        train_revert_on_disable = 1'b0; train_error_threshold = 7'h7f;
        for (i = 5; i < 8; i = i + 2) begin
            reference_period_field = i; train_enable = 1'b1; tick(3);
            `CHK("flag", 1'b1, train_error_flag_r)
        end
        reference_period_field = 3'h3;
        // stray lines in spi, sync pulses in phase 1 in psi5
        for (i = 0; i < 2; i = i + 1) begin
            train_enable = 1'b0; tick(2);
            mode = 2'(1 - i); line = 2'(2 - 2 * i); init_phase1 = i;
            period = 23'd1000; train_enable = 1'b1; run = 1'b1; tick(101000);
            `CHK("opened", 1'b0, training_active_r)
            run = 1'b0;
        end
        print_verdict;
    end
endmodule
